/* File: rtl/gir_pkg.sv */
// gir_pkg: constants and carriers for the port-expander interrupt,
// pin-drive and reset block.
// assumes: one core clock domain and one link clock domain.
package gir_pkg;

  // port width
  localparam int PORT_W = 8;
  localparam int ADDR_W = 8;

  // register offsets
  localparam logic [7:0] OFS_CONTROL = 8'h01;
  localparam logic [7:0] OFS_INPUT_STATUS = 8'h0F;
  localparam logic [7:0] OFS_INTERRUPT_MASK = 8'h11;
  localparam logic [7:0] OFS_INTERRUPT_STATUS = 8'h13;

  // control register fields
  localparam int CTL_SWRST_BIT = 0;
  localparam int CTL_RSTFLAG_BIT = 1;
  localparam int CTL_ID_LSB = 2;
  localparam int CTL_ID_W = 6;

  // reset values
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_ARMED = 8'hFF;
  localparam logic [7:0] RST_PULLDOWN = 8'hFF;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic RST_FLAG = 1'b1;

  // reset sequencer states
  typedef enum logic [0:0] {
    GIR_RUN,
    GIR_SWRST
  } gir_state_t;

  // register request carried from the link domain
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [PORT_W-1:0] wdata;
  } gir_req_t;

  // per-pin configuration from the remaining registers
  typedef struct packed {
    logic [PORT_W-1:0] direction;
    logic [PORT_W-1:0] out_level;
    logic [PORT_W-1:0] out_hiz;
    logic [PORT_W-1:0] pull_enable;
    logic [PORT_W-1:0] pull_select;
    logic [PORT_W-1:0] default_level;
  } gir_cfg_t;

endpackage

/* File: rtl/gir_sync.sv */
// gir_sync: two flip-flop synchroniser for level signals.
// assumes: input is asynchronous to clk; output read only after stage two.
`timescale 1ns/100ps
module gir_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1;

  // two stages, stage one feeds only stage two
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule

/* File: rtl/gir_top.sv */
// gir_top: interrupt, pin-drive and reset logic of an 8-bit port expander.
// assumes: serial slave engine on link_clk issues one request at a time;
// configuration inputs come from core_clk registers reset by cfg_reset.
//
// Notes on behaviour
// - unmasked set status bit pulls interrupt low
// - masked pin sets status, no interrupt
// - output pins never affect interrupt line
// - mask register at 11h, resets to zero
// - status set when input leaves default level
// - status read clears bits, releases interrupt
// - re-arm only after return to default
// - output pins never set status
// - inputs: drivers off; outputs: one driver on, none if output-disabled
// - pull paths follow enable/select; pulldown at reset
// - output pins disable input buffer
// - power-on reset loads all defaults
// - reset pin low holds defaults
// - register access only while reset pin high
// - write 1 to 01h bit 0 resets
// - software reset bit returns to zero
// - interrupt is level, active-low, open-drain
// - interrupt independent of serial clock
// - live inputs readable at 0Fh
// - direction 1 output, 0 input
// - output-disable 1 makes pin high impedance
// - output pins read zero at 0Fh
// - reset flag set by resets, cleared on read
`timescale 1ns/100ps
module gir_top #(
  parameter logic [5:0] DEVICE_ID = 6'h00 // arbitrary value
) (
  // core clock and power-on reset
  input wire logic core_clk,
  input wire logic arst_n,
  // external reset pin, active low
  input wire logic ext_reset_n,
  // link side register port
  input wire logic link_clk,
  input wire logic link_req_valid,
  input wire gir_pkg::gir_req_t link_req,
  output logic link_busy,
  output logic link_rsp_valid,
  output logic [gir_pkg::PORT_W-1:0] link_rsp_data,
  // configuration from remaining registers
  input wire gir_pkg::gir_cfg_t cfg,
  output logic cfg_reset,
  // port pins
  input wire logic [gir_pkg::PORT_W-1:0] port_pin_in,
  output logic [gir_pkg::PORT_W-1:0] port_pin_out,
  output logic [gir_pkg::PORT_W-1:0] port_pin_oe_n,
  output logic [gir_pkg::PORT_W-1:0] high_side_driver,
  output logic [gir_pkg::PORT_W-1:0] low_side_driver,
  output logic [gir_pkg::PORT_W-1:0] pullup_path,
  output logic [gir_pkg::PORT_W-1:0] pulldown_path,
  output logic [gir_pkg::PORT_W-1:0] input_buffer_en,
  // interrupt pin, open drain
  output logic int_out,
  output logic int_oe_n
);

  localparam int W = gir_pkg::PORT_W;

  // link domain
  gir_pkg::gir_req_t req_hold;
  logic req_tgl;
  logic ack_tgl_s;
  logic ack_seen;

  // core domain
  logic req_tgl_s;
  logic req_seen;
  logic ack_tgl;
  logic [W-1:0] rsp_data;
  logic ext_rst_n_s;
  logic [W-1:0] pin_s;
  gir_pkg::gir_state_t state;
  logic swrst_bit;
  logic reset_flag;
  logic [W-1:0] interrupt_mask;
  logic [W-1:0] interrupt_status;
  logic [W-1:0] armed;

  logic hold_defaults;
  logic new_req;
  logic access_ok;
  logic rd_status;
  logic rd_control;
  logic wr_mask;
  logic wr_swrst;
  logic [W-1:0] live_in;
  logic [W-1:0] event_set;
  logic [W-1:0] next_status;
  logic [W-1:0] next_armed;
  logic [W-1:0] read_value;
  logic next_int_low;

  // link side: take request when idle, hold it until acknowledged
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_hold <= '0;
      req_tgl <= 1'b0;
      link_busy <= 1'b0;
    end
    else if (link_req_valid && !link_busy)
    begin
      req_hold <= link_req;
      req_tgl <= ~req_tgl;
      link_busy <= 1'b1;
    end
    else if (ack_tgl_s != ack_seen)
    begin
      link_busy <= 1'b0;
    end
  end

  // link side: one-cycle answer pulse with held data
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_seen <= 1'b0;
      link_rsp_valid <= 1'b0;
      link_rsp_data <= gir_pkg::RST_ZERO;
    end
    else
    begin
      ack_seen <= ack_tgl_s;
      link_rsp_valid <= (ack_tgl_s != ack_seen);
      if (ack_tgl_s != ack_seen)
      begin
        link_rsp_data <= rsp_data;
      end
    end
  end

  gir_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
    .clk(link_clk),
    .arst_n(arst_n),
    .d(ack_tgl),
    .q(ack_tgl_s)
  );

  gir_sync #(.W(1), .RST_VAL(1'b0)) u_req_sync (
    .clk(core_clk),
    .arst_n(arst_n),
    .d(req_tgl),
    .q(req_tgl_s)
  );

  // reset pin held low until synchronised high
  gir_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk(core_clk),
    .arst_n(arst_n),
    .d(ext_reset_n),
    .q(ext_rst_n_s)
  );

  gir_sync #(.W(W), .RST_VAL(gir_pkg::RST_ZERO)) u_pin_sync (
    .clk(core_clk),
    .arst_n(arst_n),
    .d(port_pin_in),
    .q(pin_s)
  );

  // access decode
  always_comb
  begin
    new_req = (req_tgl_s != req_seen);
    hold_defaults = !ext_rst_n_s || (state == gir_pkg::GIR_SWRST);
    access_ok = new_req && ext_rst_n_s && (state == gir_pkg::GIR_RUN);
    rd_status = access_ok && !req_hold.write && (req_hold.addr == gir_pkg::OFS_INTERRUPT_STATUS);
    rd_control = access_ok && !req_hold.write && (req_hold.addr == gir_pkg::OFS_CONTROL);
    wr_mask = access_ok && req_hold.write && (req_hold.addr == gir_pkg::OFS_INTERRUPT_MASK);
    wr_swrst = access_ok && req_hold.write && (req_hold.addr == gir_pkg::OFS_CONTROL)
      && req_hold.wdata[gir_pkg::CTL_SWRST_BIT];
  end

  // per-pin change detection
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_pin
      always_comb
      begin
        live_in[gi] = pin_s[gi] & ~cfg.direction[gi];
        event_set[gi] = ~cfg.direction[gi] & armed[gi]
          & (pin_s[gi] ^ cfg.default_level[gi]);
        next_status[gi] = event_set[gi] | (interrupt_status[gi] & ~rd_status);
        if (event_set[gi])
        begin
          next_armed[gi] = 1'b0;
        end
        else if (~cfg.direction[gi] & (pin_s[gi] == cfg.default_level[gi]))
        begin
          next_armed[gi] = 1'b1;
        end
        else
        begin
          next_armed[gi] = armed[gi];
        end
      end
    end
  endgenerate

  // read data mux
  always_comb
  begin
    read_value = gir_pkg::RST_ZERO;
    if (access_ok && !req_hold.write)
    begin
      case (req_hold.addr)
        gir_pkg::OFS_CONTROL:
        begin
          read_value[gir_pkg::CTL_ID_LSB +: gir_pkg::CTL_ID_W] = DEVICE_ID;
          read_value[gir_pkg::CTL_RSTFLAG_BIT] = reset_flag;
        end
        gir_pkg::OFS_INPUT_STATUS: read_value = live_in;
        gir_pkg::OFS_INTERRUPT_MASK: read_value = interrupt_mask;
        gir_pkg::OFS_INTERRUPT_STATUS: read_value = interrupt_status;
        default: read_value = gir_pkg::RST_ZERO;
      endcase
    end
  end

  // interrupt level: unmasked, input pins only
  always_comb
  begin
    next_int_low = |(next_status & ~interrupt_mask & ~cfg.direction) && !hold_defaults;
  end

  // request acknowledge toward the link
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      rsp_data <= gir_pkg::RST_ZERO;
    end
    else if (new_req)
    begin
      req_seen <= req_tgl_s;
      ack_tgl <= ~ack_tgl;
      rsp_data <= read_value;
    end
  end

  // reset sequencer
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= gir_pkg::GIR_RUN;
      swrst_bit <= 1'b0;
    end
    else
    begin
      case (state)
        gir_pkg::GIR_RUN:
        begin
          if (wr_swrst)
          begin
            state <= gir_pkg::GIR_SWRST;
            swrst_bit <= 1'b1;
          end
        end
        gir_pkg::GIR_SWRST:
        begin
          state <= gir_pkg::GIR_RUN;
          swrst_bit <= 1'b0;
        end
        default:
        begin
          state <= gir_pkg::GIR_RUN;
          swrst_bit <= 1'b0;
        end
      endcase
    end
  end

  // reset flag
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reset_flag <= gir_pkg::RST_FLAG;
    end
    else if (hold_defaults || swrst_bit)
    begin
      reset_flag <= 1'b1;
    end
    else if (rd_control)
    begin
      reset_flag <= 1'b0;
    end
  end

  // interrupt mask register
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      interrupt_mask <= gir_pkg::RST_MASK;
    end
    else if (hold_defaults)
    begin
      interrupt_mask <= gir_pkg::RST_MASK;
    end
    else if (wr_mask)
    begin
      interrupt_mask <= req_hold.wdata;
    end
  end

  // sticky status and re-arm state
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      interrupt_status <= gir_pkg::RST_STATUS;
      armed <= gir_pkg::RST_ARMED;
    end
    else if (hold_defaults)
    begin
      interrupt_status <= gir_pkg::RST_STATUS;
      armed <= gir_pkg::RST_ARMED;
    end
    else
    begin
      interrupt_status <= next_status;
      armed <= next_armed;
    end
  end

  // interrupt pin, open drain
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_out <= 1'b0;
      int_oe_n <= 1'b1;
    end
    else
    begin
      int_out <= 1'b0;
      int_oe_n <= ~next_int_low;
    end
  end

  // reset request to the remaining registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_reset <= 1'b1;
    end
    else
    begin
      cfg_reset <= !ext_rst_n_s || wr_swrst;
    end
  end

  // pin drivers, pulls and input buffer
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      port_pin_out <= gir_pkg::RST_ZERO;
      port_pin_oe_n <= ~gir_pkg::RST_ZERO;
      high_side_driver <= gir_pkg::RST_ZERO;
      low_side_driver <= gir_pkg::RST_ZERO;
      pullup_path <= gir_pkg::RST_PULLUP;
      pulldown_path <= gir_pkg::RST_PULLDOWN;
      input_buffer_en <= ~gir_pkg::RST_ZERO;
    end
    else if (hold_defaults)
    begin
      port_pin_out <= gir_pkg::RST_ZERO;
      port_pin_oe_n <= ~gir_pkg::RST_ZERO;
      high_side_driver <= gir_pkg::RST_ZERO;
      low_side_driver <= gir_pkg::RST_ZERO;
      pullup_path <= gir_pkg::RST_PULLUP;
      pulldown_path <= gir_pkg::RST_PULLDOWN;
      input_buffer_en <= ~gir_pkg::RST_ZERO;
    end
    else
    begin
      port_pin_out <= cfg.out_level;
      port_pin_oe_n <= ~(cfg.direction & ~cfg.out_hiz);
      high_side_driver <= cfg.direction & ~cfg.out_hiz & cfg.out_level;
      low_side_driver <= cfg.direction & ~cfg.out_hiz & ~cfg.out_level;
      pullup_path <= cfg.pull_enable & cfg.pull_select;
      pulldown_path <= cfg.pull_enable & ~cfg.pull_select;
      input_buffer_en <= ~cfg.direction;
    end
  end

endmodule

/* File: tb/gir_master.sv */
// gir_master: link-side request model of the serial master.
// assumes: link_clk runs free; one request outstanding at a time.
`timescale 1ns/100ps
module gir_master (
  // link clock
  input wire logic link_clk,
  // request
  output gir_pkg::gir_req_t link_req,
  output logic link_req_valid,
  // answer
  input wire logic link_busy,
  input wire logic link_rsp_valid,
  input wire logic [gir_pkg::PORT_W-1:0] link_rsp_data
);
  initial
  begin
    link_req_valid = 1'b0;
    link_req = '0;
  end
  // one byte per access, taken at a rising edge with busy low
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    q = 'x;
    @(negedge link_clk);
    link_req_valid = 1'b1;
    link_req = '{wr, a, d};
    @(negedge link_clk);
    link_req_valid = 1'b0;
    link_req = ~link_req;
    for (n = 0; n < 16 && !link_rsp_valid; n++) @(negedge link_clk);
    if (link_rsp_valid) q = link_rsp_data;
  endtask
endmodule

/* File: tb/gir_top_props.sv */
// gir_top_props: port assertions for gir_top.
// assumes: bound into gir_top; cfg comes from core_clk registers.
`timescale 1ns/100ps
module gir_top_props (
  // clocks and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic link_clk,
  // link side
  input wire logic link_req_valid,
  input wire logic link_busy,
  input wire logic link_rsp_valid,
  // configuration
  input wire gir_pkg::gir_cfg_t cfg,
  input wire logic cfg_reset,
  // pins
  input wire logic [gir_pkg::PORT_W-1:0] port_pin_oe_n,
  input wire logic [gir_pkg::PORT_W-1:0] high_side_driver,
  input wire logic [gir_pkg::PORT_W-1:0] low_side_driver,
  input wire logic [gir_pkg::PORT_W-1:0] pullup_path,
  input wire logic [gir_pkg::PORT_W-1:0] pulldown_path,
  input wire logic [gir_pkg::PORT_W-1:0] input_buffer_en,
  input wire logic int_out,
  input wire logic int_oe_n
);
  a_drive_follow: assert property (@(posedge core_clk) disable iff (!arst_n || cfg_reset)
    1 |=> high_side_driver == $past(cfg.direction & ~cfg.out_hiz & cfg.out_level)
    && low_side_driver == $past(cfg.direction & ~cfg.out_hiz & ~cfg.out_level))
    else $error("driver enables wrong");
  a_pull_follow: assert property (@(posedge core_clk) disable iff (!arst_n || cfg_reset)
    1 |=> pullup_path == $past(cfg.pull_enable & cfg.pull_select)
    && pulldown_path == $past(cfg.pull_enable & ~cfg.pull_select))
    else $error("pull paths wrong");
  a_buffer_oe: assert property (@(posedge core_clk) disable iff (!arst_n || cfg_reset)
    1 |=> input_buffer_en == ~$past(cfg.direction)
    && port_pin_oe_n == ~$past(cfg.direction & ~cfg.out_hiz))
    else $error("buffer or pin enable wrong");
  a_outputs_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
    cfg.direction == 8'hFF |=> int_oe_n)
    else $error("interrupt from output pins");
  a_open_drain: assert property (@(posedge core_clk) disable iff (!arst_n)
    !int_oe_n |-> int_out == 1'b0)
    else $error("interrupt pin driven high");
  a_reset_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    cfg_reset [*3] |-> port_pin_oe_n == 8'hFF && high_side_driver == 8'h00
    && low_side_driver == 8'h00 && int_oe_n)
    else $error("outputs not held in reset");
  a_answer_bound: assert property (@(posedge link_clk) disable iff (!arst_n)
    link_req_valid && !link_busy |=> link_busy ##[3:9] link_rsp_valid)
    else $error("request not answered");
  a_busy_release: assert property (@(posedge link_clk) disable iff (!arst_n)
    link_rsp_valid |-> !link_busy ##1 !link_rsp_valid)
    else $error("answer pulse or busy wrong");
endmodule

bind gir_top gir_top_props u_gir_top_props (.core_clk, .arst_n, .link_clk, .link_req_valid,
  .link_busy, .link_rsp_valid, .cfg, .cfg_reset, .port_pin_oe_n, .high_side_driver,
  .low_side_driver, .pullup_path, .pulldown_path, .input_buffer_en, .int_out, .int_oe_n);

/* File: tb/tb.sv */
// tb: self-checking bench for gir_top.
// assumes: gir_master drives the link; cfg models the outside registers.
`timescale 1ns/100ps
module tb;
  typedef struct packed { logic [47:0] c; logic [47:0] e; } gir_row_t;
  localparam logic [47:0] CFG_DEF = 48'h0000_FFFF_0000;
  localparam logic [47:0] DRV_DEF = 48'h0000_FF00_FFFF;
  localparam logic [5:0] DEV_ID = 6'h2A; // arbitrary value
  localparam int RESET_PULSE_MIN = 8;
  localparam gir_row_t ROWS [4] = '{
    '{48'hF0A5_303C_0F00, 48'h8040_3F0C_300F},
    '{48'hFF0F_00FF_FF00, 48'h0FF0_00FF_0000},
    '{48'h00FF_0000_AA00, 48'h0000_FF00_00FF},
    '{48'h5533_11F0_3C00, 48'h0044_BB30_C0AA}};
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic arst_n = 1'b0;
  logic ext_reset_n = 1'b1;
  gir_pkg::gir_cfg_t cfg = CFG_DEF;
  logic [7:0] ext_pins = 8'h00;
  logic link_req_valid, link_busy, link_rsp_valid, cfg_reset, int_out, int_oe_n;
  gir_pkg::gir_req_t link_req;
  logic [7:0] link_rsp_data, pin_in, pin_out, oe_n, hsd, lsd, pu, pd, ibuf, q;
  logic [47:0] drv;
  logic int_line;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  assign drv = {hsd, lsd, oe_n, pu, pd, ibuf};
  assign pin_in = (~oe_n & pin_out) | (oe_n & ext_pins);
  assign int_line = int_oe_n ? 1'b1 : int_out;

  gir_top #(.DEVICE_ID(DEV_ID)) u_gir_top (.core_clk, .arst_n, .ext_reset_n, .link_clk,
    .link_req_valid, .link_req, .link_busy, .link_rsp_valid, .link_rsp_data, .cfg, .cfg_reset,
    .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe_n(oe_n), .high_side_driver(hsd),
    .low_side_driver(lsd), .pullup_path(pu), .pulldown_path(pd), .input_buffer_en(ibuf),
    .int_out, .int_oe_n);
  gir_master u_gir_master (.link_clk, .link_req_valid, .link_req, .link_busy, .link_rsp_valid,
    .link_rsp_data);

  always #12.5 core_clk = ~core_clk;
  always #32 link_clk = ~link_clk;
  // outside registers take defaults on request
  always @(negedge core_clk) if (cfg_reset) cfg <= CFG_DEF;
  always @(posedge core_clk) if (++cyc == 20000)
  begin
    n_fail++;
    print_verdict();
  end

  task automatic print_verdict();
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    u_gir_master.access(wr, a, d, q);
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk({40'h0, q}, {40'h0, exp});
  endtask

  initial
  begin
    wc(10);
    arst_n = 1'b1;
    wc(6);
    chk(drv, DRV_DEF);
    rd(gir_pkg::OFS_INTERRUPT_MASK, 8'h00);
    rd(gir_pkg::OFS_CONTROL, {DEV_ID, 2'b10});
    rd(gir_pkg::OFS_CONTROL, {DEV_ID, 2'b00});
    foreach (ROWS[i])
    begin
      cfg = ROWS[i].c;
      wc(2);
      chk(drv, ROWS[i].e);
      chk({40'h0, pin_out}, {40'h0, cfg.out_level});
    end
    cfg = CFG_DEF;
    // drop events left by driven pins turning back to inputs
    wc(4);
    acc(1'b0, gir_pkg::OFS_INTERRUPT_STATUS, 8'h00);
    acc(1'b1, gir_pkg::OFS_INTERRUPT_MASK, 8'hF0);
    rd(gir_pkg::OFS_INTERRUPT_MASK, 8'hF0);
    ext_pins = 8'h81;
    wc(5);
    chk({47'h0, int_line}, 48'h0);
    rd(gir_pkg::OFS_INPUT_STATUS, 8'h81);
    rd(gir_pkg::OFS_INTERRUPT_STATUS, 8'h81);
    chk({47'h0, int_line}, 48'h1);
    rd(gir_pkg::OFS_INTERRUPT_STATUS, 8'h00);
    ext_pins = 8'h00;
    wc(5);
    ext_pins = 8'h80;
    wc(5);
    chk({47'h0, int_line}, 48'h1);
    cfg.default_level = 8'h02;
    ext_pins = 8'h81;
    wc(5);
    chk({47'h0, int_line}, 48'h0);
    rd(gir_pkg::OFS_INTERRUPT_STATUS, 8'h83);
    cfg = {8'h0F, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
    ext_pins = 8'h1F;
    wc(5);
    chk({47'h0, int_line}, 48'h1);
    rd(gir_pkg::OFS_INTERRUPT_STATUS, 8'h10);
    rd(gir_pkg::OFS_INPUT_STATUS, 8'h10);
    ext_pins = 8'h00;
    cfg = CFG_DEF;
    acc(1'b1, 8'h02, 8'hFF);
    rd(8'h02, 8'h00);
    acc(1'b1, gir_pkg::OFS_INTERRUPT_MASK, 8'h5A);
    ext_reset_n = 1'b0;
    wc(RESET_PULSE_MIN);
    chk({47'h0, cfg_reset}, 48'h1);
    chk(drv, DRV_DEF);
    acc(1'b1, gir_pkg::OFS_INTERRUPT_MASK, 8'hFF);
    chk({40'h0, q}, 48'h0);
    rd(gir_pkg::OFS_CONTROL, 8'h00);
    ext_reset_n = 1'b1;
    wc(6);
    rd(gir_pkg::OFS_INTERRUPT_MASK, 8'h00);
    rd(gir_pkg::OFS_CONTROL, {DEV_ID, 2'b10});
    acc(1'b1, gir_pkg::OFS_INTERRUPT_MASK, 8'h33);
    cfg = ROWS[1].c;
    acc(1'b1, gir_pkg::OFS_CONTROL, 8'h01);
    wc(3);
    chk(cfg, CFG_DEF);
    chk(drv, DRV_DEF);
    rd(gir_pkg::OFS_INTERRUPT_MASK, 8'h00);
    rd(gir_pkg::OFS_CONTROL, {DEV_ID, 2'b10});
    print_verdict();
  end
endmodule
